// ---- src/sx_motion_cmd.sv ----
// Purpose: Command decode and motion engine of a stepper indexer
// Assumes: Commands arrive already parsed; sequence engine is on this clock
// Notes:   Registers reached over Wishbone classic, one cycle answer
//
// Contract
// R1: Commands carry single, optional or no address
// R2: Non-starred commands need standstill and no sequence
// R3: Direction commands set later relative move direction
// R4: Slip threshold up to 255, default 10
// R5: Threshold changes only between sequences
// R6: Stall tolerance errors 0 and 1
// R7: Origin init clears absolute step counter
// R8: Reset and memory reset clear counter
// R9: Origin init refused while moving or sequencing
// R10: Reference redefined without motion, old frame value
// R11: Reference errors give code 0
// R12: Reference zero acts like origin init
// R13: Relative count stored, at most 999998
// R14: Relative count survives power loss
// R15: Relative distance errors 0 and 1
// R16: Absolute move starts at once to target
// R17: Profile computed before first move after speed change
// R18: No motion when already at target
// R19: Absolute move errors 0 and 1
// R20: Absolute move to zero equals return origin
// R21: Decelerating stop ramps to lowest speed, halts
// R22: Full step outputs go FF after stop
// R23: State refusal sets unauthorised status code
// R24: Direction and count persist until replaced
`timescale 1ns/1ps
`default_nettype none

module sx_motion_cmd #(
  parameter int          PROF_CYC = sx_pkg::PROF_CALC_CYC,
  parameter logic [15:0] VMIN_DEF = sx_pkg::VMIN_RESET,
  parameter logic [15:0] VMAX_DEF = sx_pkg::VMAX_RESET
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        seq_running_i,
  input  wire logic [19:0] nv_rel_count_i,
  output logic             nv_write_o,
  output logic      [19:0] rel_count_o,
  output logic             dir_cw_o,
  output logic      [7:0]  slip_threshold_o,
  output logic             seq_abort_o,
  output logic             step_o,
  output logic             step_dir_o,
  output logic      [7:0]  logic_out_o
);

  // Bus registers
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] param_reg;
  logic [5:0]  mod_addr_reg;
  logic        micro_reg;
  logic [15:0] vmin_reg;
  logic [15:0] vmax_reg;
  logic [7:0]  outs_reg;
  logic [7:0]  status_reg;

  // Command state
  logic        dir_cw_reg;
  logic [7:0]  slip_reg;
  logic [7:0]  slip_pend_reg;
  logic        slip_upd_reg;
  logic [19:0] rel_reg;
  logic        nv_wr_reg;
  logic        abort_reg;

  // Motion state
  sx_pkg::sx_mv_t mv_reg;
  logic signed [31:0] pos_reg;
  logic signed [31:0] target_reg;
  logic [15:0] period_reg;
  logic [15:0] tick_reg;
  logic [31:0] ramp_reg;
  logic        calc_dirty_reg;
  logic [31:0] calc_cnt_reg;
  logic        step_reg;
  logic        stop_ff_reg;

  // Bus decode
  logic            bus_req;
  logic            wr_fire;
  sx_pkg::sx_cmd_t cmd;
  logic            cmd_fire;

  assign bus_req  = wb_cyc_i & wb_stb_i;
  assign wr_fire  = bus_req & wb_we_i & ack_reg & (&wb_sel_i);
  assign cmd      = sx_pkg::sx_cmd_t'(wb_dat_i[14:0]);
  assign cmd_fire = wr_fire & (wb_adr_i == sx_pkg::ADDR_CMD);

  // Command classification
  logic        moving;
  logic        addr_ok;
  logic        star_cmd;
  logic        known;
  logic        state_bad;
  logic [31:0] mag;
  logic        param_bad;
  logic        ok_exec;
  logic [7:0]  err_code;
  sx_pkg::sx_adr_t adr_cls;

  assign moving = (mv_reg != sx_pkg::MV_IDLE);
  assign mag    = param_reg[31] ? (32'h0 - param_reg) : param_reg;

  always_comb begin
    case (cmd.opcode)
      sx_pkg::OP_MEM_RST: adr_cls = sx_pkg::ADR_ALL;
      default:            adr_cls = sx_pkg::ADR_ANY;
    endcase
  end

  always_comb begin
    case (adr_cls) // see R1
      sx_pkg::ADR_ONE: addr_ok = cmd.addr_given & (cmd.addr == mod_addr_reg);
      sx_pkg::ADR_ANY: addr_ok = !cmd.addr_given | (cmd.addr == mod_addr_reg);
      default:         addr_ok = 1'b1;
    endcase
  end

  assign star_cmd  = (cmd.opcode == sx_pkg::OP_DECEL);
  assign state_bad = !star_cmd & (moving | seq_running_i); // see R2, R9

  always_comb begin
    known     = 1'b1;
    param_bad = 1'b0;
    err_code  = sx_pkg::ST_NONE;
    case (cmd.opcode)
      sx_pkg::OP_DIR_CW, sx_pkg::OP_DIR_CCW: begin
        known = !micro_reg; // see R3
      end
      sx_pkg::OP_STALL_TOL: begin
        if (!cmd.p_present | !cmd.p_numeric | cmd.p_ovf) begin // see R6
          param_bad = 1'b1;
          err_code  = sx_pkg::ST_PARAM;
        end else if (param_reg[31] | (param_reg > sx_pkg::SLIP_MAX)) begin
          param_bad = 1'b1;
          err_code  = sx_pkg::ST_RANGE;
        end
      end
      sx_pkg::OP_REF_POS: begin
        if (!cmd.p_present | !cmd.p_numeric | cmd.p_ovf |
            (!micro_reg & (mag > sx_pkg::FULL_MAX))) begin // see R11
          param_bad = 1'b1;
          err_code  = sx_pkg::ST_PARAM;
        end
      end
      sx_pkg::OP_REL_DIST: begin
        known = !micro_reg;
        if (!cmd.p_present | !cmd.p_numeric | cmd.p_signed | cmd.p_ovf) begin // see R15
          param_bad = 1'b1;
          err_code  = sx_pkg::ST_PARAM;
        end else if (param_reg > sx_pkg::REL_MAX) begin
          param_bad = 1'b1;
          err_code  = sx_pkg::ST_RANGE;
        end
      end
      sx_pkg::OP_ABS_MOVE: begin
        if (!cmd.p_present | !cmd.p_numeric | cmd.p_ovf) begin // see R19
          param_bad = 1'b1;
          err_code  = sx_pkg::ST_PARAM;
        end else if (!micro_reg & (mag > sx_pkg::FULL_MAX)) begin
          param_bad = 1'b1;
          err_code  = sx_pkg::ST_RANGE;
        end
      end
      sx_pkg::OP_ORIGIN, sx_pkg::OP_DECEL,
      sx_pkg::OP_RET_ORIG, sx_pkg::OP_MEM_RST: begin
        known = 1'b1;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  assign ok_exec = cmd_fire & addr_ok & known & !state_bad & !param_bad;

  // Wishbone answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & !ack_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0;
    end else if (bus_req & !ack_reg) begin
      case (wb_adr_i)
        sx_pkg::ADDR_CMD:    rdata_reg <= {24'h0, status_reg};
        sx_pkg::ADDR_PARAM:  rdata_reg <= param_reg;
        sx_pkg::ADDR_CONFIG: rdata_reg <= {23'h0, micro_reg, 2'h0, mod_addr_reg};
        sx_pkg::ADDR_SPEED:  rdata_reg <= {vmin_reg, vmax_reg};
        sx_pkg::ADDR_STATUS: rdata_reg <= {16'h0, status_reg, 1'b0, slip_upd_reg,
                                           calc_dirty_reg, dir_cw_reg, seq_running_i,
                                           mv_reg, moving};
        sx_pkg::ADDR_POS:    rdata_reg <= pos_reg;
        sx_pkg::ADDR_SLIP:   rdata_reg <= {24'h0, slip_reg};
        sx_pkg::ADDR_REL:    rdata_reg <= {12'h0, rel_reg};
        sx_pkg::ADDR_OUTS:   rdata_reg <= {24'h0, outs_reg};
        default:             rdata_reg <= 32'h0;
      endcase
    end
  end

  // Software configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      param_reg    <= 32'h0;
      mod_addr_reg <= sx_pkg::MOD_ADDR_RESET;
      micro_reg    <= 1'b0;
    end else if (wr_fire) begin
      if (wb_adr_i == sx_pkg::ADDR_PARAM) begin
        param_reg <= wb_dat_i;
      end
      if (wb_adr_i == sx_pkg::ADDR_CONFIG) begin
        mod_addr_reg <= wb_dat_i[sx_pkg::CFG_ADDR_LSB +: 6];
        micro_reg    <= wb_dat_i[sx_pkg::CFG_MICRO_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vmin_reg <= VMIN_DEF;
      vmax_reg <= VMAX_DEF;
    end else if (wr_fire & (wb_adr_i == sx_pkg::ADDR_SPEED)) begin
      vmax_reg <= wb_dat_i[15:0];
      vmin_reg <= wb_dat_i[31:16];
    end
  end

  // Status code of the last command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= sx_pkg::ST_NONE;
    end else if (cmd_fire & addr_ok) begin
      if (!known) begin
        status_reg <= sx_pkg::ST_UNKNOWN;
      end else if (state_bad) begin
        status_reg <= sx_pkg::ST_STATE; // see R23
      end else if (param_bad) begin
        status_reg <= err_code;
      end else if (cmd.opcode == sx_pkg::OP_MEM_RST) begin
        status_reg <= sx_pkg::ST_MEMRST;
      end else begin
        status_reg <= sx_pkg::ST_NONE;
      end
    end
  end

  // Direction of relative moves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_cw_reg <= 1'b1;
    end else if (ok_exec & (cmd.opcode == sx_pkg::OP_DIR_CW)) begin
      dir_cw_reg <= 1'b1; // see R3, R24
    end else if (ok_exec & (cmd.opcode == sx_pkg::OP_DIR_CCW)) begin
      dir_cw_reg <= 1'b0;
    end
  end

  // Slip threshold, held during sequences
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slip_reg      <= sx_pkg::SLIP_RESET; // see R4
      slip_pend_reg <= sx_pkg::SLIP_RESET;
      slip_upd_reg  <= 1'b0;
    end else if (ok_exec & (cmd.opcode == sx_pkg::OP_STALL_TOL)) begin
      slip_pend_reg <= param_reg[7:0];
      slip_upd_reg  <= 1'b1;
    end else if (slip_upd_reg & !seq_running_i) begin
      slip_reg     <= slip_pend_reg; // see R5
      slip_upd_reg <= 1'b0;
    end
  end

  // Relative step count, restored from non-volatile copy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rel_reg   <= nv_rel_count_i; // see R14
      nv_wr_reg <= 1'b0;
    end else begin
      nv_wr_reg <= 1'b0;
      if (ok_exec & (cmd.opcode == sx_pkg::OP_REL_DIST)) begin
        rel_reg   <= param_reg[19:0]; // see R13, R24
        nv_wr_reg <= 1'b1;
      end
    end
  end

  // Profile computation after a speed change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      calc_dirty_reg <= 1'b1;
      calc_cnt_reg   <= 32'h0;
    end else if (wr_fire & (wb_adr_i == sx_pkg::ADDR_SPEED)) begin
      calc_dirty_reg <= 1'b1;
      calc_cnt_reg   <= 32'h0;
    end else if (mv_reg == sx_pkg::MV_CALC) begin
      if (calc_cnt_reg >= 32'(PROF_CYC - 1)) begin
        calc_dirty_reg <= 1'b0; // see R17
      end else begin
        calc_cnt_reg <= calc_cnt_reg + 32'h1;
      end
    end
  end

  // Motion engine
  logic start_move;
  logic signed [31:0] new_target;
  logic [31:0] remain;
  logic        tick_hit;
  logic        at_target;

  assign new_target = (cmd.opcode == sx_pkg::OP_RET_ORIG) ? 32'sh0 : param_reg; // see R20
  assign start_move = ok_exec & ((cmd.opcode == sx_pkg::OP_ABS_MOVE) |
                                 (cmd.opcode == sx_pkg::OP_RET_ORIG));
  assign remain     = (target_reg > pos_reg) ? 32'(target_reg - pos_reg)
                                             : 32'(pos_reg - target_reg);
  assign tick_hit   = (tick_reg >= period_reg);
  assign at_target  = (pos_reg == target_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mv_reg      <= sx_pkg::MV_IDLE;
      target_reg  <= 32'sh0;
      period_reg  <= VMIN_DEF;
      tick_reg    <= 16'h0;
      ramp_reg    <= 32'h0;
      step_reg    <= 1'b0;
      stop_ff_reg <= 1'b0;
    end else begin
      step_reg    <= 1'b0;
      stop_ff_reg <= 1'b0;
      case (mv_reg)
        sx_pkg::MV_IDLE: begin
          period_reg <= vmin_reg; // see R21
          tick_reg   <= 16'h0;
          ramp_reg   <= 32'h0;
          if (start_move & (new_target != pos_reg)) begin // see R16, R18
            target_reg <= new_target;
            mv_reg     <= calc_dirty_reg ? sx_pkg::MV_CALC : sx_pkg::MV_RUN;
          end
        end
        sx_pkg::MV_CALC: begin
          if (!calc_dirty_reg) begin
            mv_reg <= sx_pkg::MV_RUN; // see R17
          end
        end
        sx_pkg::MV_RUN: begin
          if (ok_exec & (cmd.opcode == sx_pkg::OP_DECEL)) begin
            mv_reg <= sx_pkg::MV_DECEL;
          end else if (at_target) begin
            mv_reg <= sx_pkg::MV_IDLE;
          end else if (tick_hit) begin
            tick_reg <= 16'h0;
            step_reg <= 1'b1;
            if (remain <= ramp_reg + 32'h1) begin
              period_reg <= (period_reg + sx_pkg::ACC_DELTA > vmin_reg) ? vmin_reg
                            : period_reg + sx_pkg::ACC_DELTA;
              ramp_reg   <= (ramp_reg == 32'h0) ? 32'h0 : ramp_reg - 32'h1;
            end else if (period_reg > vmax_reg + sx_pkg::ACC_DELTA) begin
              period_reg <= period_reg - sx_pkg::ACC_DELTA;
              ramp_reg   <= ramp_reg + 32'h1;
            end
          end else begin
            tick_reg <= tick_reg + 16'h1;
          end
        end
        sx_pkg::MV_DECEL: begin
          if (at_target | (period_reg >= vmin_reg)) begin
            mv_reg      <= sx_pkg::MV_IDLE; // see R21
            stop_ff_reg <= !micro_reg;
          end else if (tick_hit) begin
            tick_reg   <= 16'h0;
            step_reg   <= 1'b1;
            period_reg <= period_reg + sx_pkg::ACC_DELTA;
          end else begin
            tick_reg <= tick_reg + 16'h1;
          end
        end
        default: begin
          mv_reg <= sx_pkg::MV_IDLE;
        end
      endcase
      if (ok_exec & (cmd.opcode == sx_pkg::OP_MEM_RST)) begin
        mv_reg <= sx_pkg::MV_IDLE;
      end
    end
  end

  // Absolute step counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_reg <= 32'sh0; // see R8
    end else if (ok_exec & ((cmd.opcode == sx_pkg::OP_ORIGIN) |
                            (cmd.opcode == sx_pkg::OP_MEM_RST) |
                            ((cmd.opcode == sx_pkg::OP_REF_POS) & (param_reg == 32'h0)))) begin
      pos_reg <= 32'sh0; // see R7, R8, R12
    end else if (ok_exec & (cmd.opcode == sx_pkg::OP_REF_POS)) begin
      pos_reg <= pos_reg - param_reg; // see R10
    end else if (step_reg) begin
      pos_reg <= (target_reg > pos_reg) ? pos_reg + 32'sh1 : pos_reg - 32'sh1;
    end
  end

  // Decelerating stop also ends a running sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      abort_reg <= 1'b0;
    end else begin
      abort_reg <= ok_exec & (cmd.opcode == sx_pkg::OP_DECEL) & seq_running_i; // see R21
    end
  end

  // Logical outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      outs_reg <= sx_pkg::OUTS_IDLE;
    end else if (stop_ff_reg | (ok_exec & (cmd.opcode == sx_pkg::OP_DECEL) &
                                !moving & !micro_reg)) begin
      outs_reg <= sx_pkg::OUTS_IDLE; // see R22
    end else if (wr_fire & (wb_adr_i == sx_pkg::ADDR_OUTS)) begin
      outs_reg <= wb_dat_i[7:0];
    end
  end

  assign wb_ack_o         = ack_reg;
  assign wb_dat_o         = rdata_reg;
  assign nv_write_o       = nv_wr_reg;
  assign rel_count_o      = rel_reg;
  assign dir_cw_o         = dir_cw_reg;
  assign slip_threshold_o = slip_reg;
  assign seq_abort_o      = abort_reg;
  assign step_o           = step_reg;
  assign step_dir_o       = (target_reg > pos_reg);
  assign logic_out_o      = outs_reg;

endmodule

`default_nettype wire

// ---- src/sx_pkg.sv ----
// Purpose: Shared constants and types for the stepper indexer motion command block
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes:   Status codes are the ASCII characters reported to the host
package sx_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_PARAM  = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_SPEED  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_POS    = 8'h14;
  localparam logic [7:0] ADDR_SLIP   = 8'h18;
  localparam logic [7:0] ADDR_REL    = 8'h1c;
  localparam logic [7:0] ADDR_OUTS   = 8'h20;

  // CONFIG field positions
  localparam int CFG_ADDR_LSB  = 0;
  localparam int CFG_MICRO_BIT = 8;

  // Reset values
  localparam logic [7:0]  SLIP_RESET     = 8'h0a;
  localparam logic [7:0]  OUTS_IDLE      = 8'hff;
  localparam logic [5:0]  MOD_ADDR_RESET = 6'h00;
  localparam logic [15:0] VMIN_RESET     = 16'h0400;
  localparam logic [15:0] VMAX_RESET     = 16'h0040;

  // Limits
  localparam logic [31:0] SLIP_MAX   = 32'h0000_00ff;
  localparam logic [31:0] REL_MAX    = 32'h000f_423e;
  localparam logic [31:0] FULL_MAX   = 32'h007f_ffff;
  localparam logic [15:0] ACC_DELTA  = 16'h0010;

  // Profile computation time
  localparam int CLK_MHZ       = 250;
  localparam int PROF_CALC_NS  = 2000;
  localparam int PROF_CALC_CYC = (PROF_CALC_NS * CLK_MHZ + 999) / 1000;

  // Status codes
  localparam logic [7:0] ST_NONE    = 8'h4e;
  localparam logic [7:0] ST_STATE   = 8'h41;
  localparam logic [7:0] ST_UNKNOWN = 8'h43;
  localparam logic [7:0] ST_PARAM   = 8'h30;
  localparam logic [7:0] ST_RANGE   = 8'h31;
  localparam logic [7:0] ST_MEMRST  = 8'h4d;

  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_DIR_CW    = 4'h1,
    OP_DIR_CCW   = 4'h2,
    OP_STALL_TOL = 4'h3,
    OP_ORIGIN    = 4'h4,
    OP_REF_POS   = 4'h5,
    OP_REL_DIST  = 4'h6,
    OP_ABS_MOVE  = 4'h7,
    OP_DECEL     = 4'h8,
    OP_RET_ORIG  = 4'h9,
    OP_MEM_RST   = 4'ha
  } sx_op_t;

  typedef enum logic [1:0] {
    ADR_ONE = 2'h0,
    ADR_ANY = 2'h1,
    ADR_ALL = 2'h2
  } sx_adr_t;

  // Parsed command word written to ADDR_CMD
  typedef struct packed {
    logic        addr_given;
    logic [5:0]  addr;
    logic        p_present;
    logic        p_numeric;
    logic        p_signed;
    logic        p_ovf;
    sx_op_t      opcode;
  } sx_cmd_t;

  typedef enum logic [1:0] {
    MV_IDLE  = 2'h0,
    MV_CALC  = 2'h1,
    MV_RUN   = 2'h2,
    MV_DECEL = 2'h3
  } sx_mv_t;

endpackage

// ---- tb/sx_motion_cmd_sva.sv ----
// Purpose: Port-level assertions for the motion command block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module sx_motion_cmd_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        seq_running_i,
  input wire logic [19:0] nv_rel_count_i,
  input wire logic        nv_write_o,
  input wire logic [19:0] rel_count_o,
  input wire logic        dir_cw_o,
  input wire logic [7:0]  slip_threshold_o,
  input wire logic        seq_abort_o,
  input wire logic        step_o,
  input wire logic [7:0]  logic_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_done;
  logic decel_done;
  assign wr_done    = wb_ack_o && wb_we_i;
  assign decel_done = wr_done && wb_adr_i == sx_pkg::ADDR_CMD && wb_dat_i[3:0] == 4'h8;
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");
  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  property p_reset_vals;
    $fell(rst_i) |-> logic_out_o == sx_pkg::OUTS_IDLE && slip_threshold_o == sx_pkg::SLIP_RESET
      && rel_count_o == $past(nv_rel_count_i);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad values after reset");
  property p_slip_hold; seq_running_i |=> $stable(slip_threshold_o); endproperty
  a_slip_hold: assert property (p_slip_hold) else $error("threshold moved in sequence");
  property p_abort_cause; seq_abort_o |-> $past(decel_done); endproperty
  a_abort_cause: assert property (p_abort_cause) else $error("abort without stop");
  property p_nv_cause; nv_write_o |-> $past(wr_done); endproperty
  a_nv_cause: assert property (p_nv_cause) else $error("store without write");
  property p_dir_cause; $changed(dir_cw_o) && !$past(rst_i) |-> $past(wr_done); endproperty
  a_dir_cause: assert property (p_dir_cause) else $error("direction changed alone");
  property p_rel_cause; $changed(rel_count_o) && !$past(rst_i) |-> $past(wr_done); endproperty
  a_rel_cause: assert property (p_rel_cause) else $error("count changed alone");
  property p_step_pulse; step_o |=> !step_o; endproperty
  a_step_pulse: assert property (p_step_pulse) else $error("step pulse too long");
  c_abort: cover property (seq_abort_o);
  c_step: cover property (step_o ##1 !step_o);
  c_store: cover property (nv_write_o);
endmodule
bind sx_motion_cmd sx_motion_cmd_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_ack_o, .seq_running_i, .nv_rel_count_i, .nv_write_o, .rel_count_o,
  .dir_cw_o, .slip_threshold_o, .seq_abort_o, .step_o, .logic_out_o);
`default_nettype wire

// ---- tb/sx_motion_cmd_test.sv ----
// Purpose: Self-checking bench for the motion command block
// Assumes: Full-step mode, module address 0, short profile time
// Notes:   Scenarios run in order, each judges its own results
`timescale 1ns/1ps
`default_nettype none
module sx_motion_cmd_test;
  localparam logic [3:0] F_OK = 4'hc;
  localparam logic [3:0] F_NEG = 4'he;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic        seq_run = 1'b0;
  logic [31:0] rdat, q;
  logic        ack, nv_wr, dir_cw, abort, step, step_dir;
  logic [19:0] nv_rel, rel_cnt;
  logic [7:0]  slip, outs;
  int          err_total = 0;
  int          total_checks = 0;
  int          net = 0;
  int          aborts = 0;
  int          s;
  always #2 clk_i = ~clk_i;
  sx_motion_cmd #(.PROF_CYC(4)) uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .seq_running_i(seq_run), .nv_rel_count_i(nv_rel), .nv_write_o(nv_wr),
    .rel_count_o(rel_cnt), .dir_cw_o(dir_cw), .slip_threshold_o(slip), .seq_abort_o(abort),
    .step_o(step), .step_dir_o(step_dir), .logic_out_o(outs));
  sx_nv_model nv (.clk_i, .nv_write_i(nv_wr), .rel_count_i(rel_cnt), .nv_rel_count_o(nv_rel));
  always @(posedge clk_i) begin
    if (step === 1'b1) net <= step_dir ? net + 1 : net - 1;
    if (abort === 1'b1) aborts <= aborts + 1;
  end
  task automatic wrap_up;
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      wrap_up();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(n, q, e);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [31:0] p, input logic [3:0] f,
                     input logic [7:0] st);
    wb(1'b1, sx_pkg::ADDR_PARAM, p);
    wb(1'b1, sx_pkg::ADDR_CMD, {17'h0, 1'b1, 6'h00, f, op});
    rd("status", sx_pkg::ADDR_CMD, {24'h0, st});
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      wb(1'b0, sx_pkg::ADDR_STATUS, 32'h0);
      n++;
    end while (q[2:0] !== 3'h0 && n < 3000);
    if (n >= 3000) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic t_reset;
    check("slip", slip, 32'd10);
    check("outs", outs, 32'hff);
    check("rel", rel_cnt, 32'h01234);
    rd("pos", sx_pkg::ADDR_POS, 32'h0);
    rd("unmapped", 8'h3c, 32'h0);
  endtask
  task automatic t_params;
    cmd(4'h3, 32'd255, F_OK, sx_pkg::ST_NONE);
    cmd(4'h3, 32'd256, F_OK, sx_pkg::ST_RANGE);
    cmd(4'h3, 32'd0, 4'h0, sx_pkg::ST_PARAM);
    check("slip", slip, 32'd255);
    cmd(4'h6, 32'd999998, F_OK, sx_pkg::ST_NONE);
    cmd(4'h6, 32'd999999, F_OK, sx_pkg::ST_RANGE);
    cmd(4'h6, 32'd5, F_NEG, sx_pkg::ST_PARAM);
    check("rel", rel_cnt, 32'd999998);
    check("nv", nv_rel, 32'd999998);
    cmd(4'h2, 32'd0, 4'h0, sx_pkg::ST_NONE);
    check("dir", dir_cw, 32'd0);
    cmd(4'h1, 32'd0, 4'h0, sx_pkg::ST_NONE);
    check("dir", dir_cw, 32'd1);
    cmd(4'hf, 32'd0, 4'h0, sx_pkg::ST_UNKNOWN);
    wb(1'b1, sx_pkg::ADDR_CONFIG, 32'h5);
    cmd(4'h2, 32'd0, 4'h0, sx_pkg::ST_UNKNOWN);
    check("dir", dir_cw, 32'd1);
    wb(1'b1, sx_pkg::ADDR_CMD, 32'h2);
    check("dir", dir_cw, 32'd0);
    wb(1'b1, sx_pkg::ADDR_CONFIG, 32'h100);
    cmd(4'h1, 32'd0, 4'h0, sx_pkg::ST_UNKNOWN);
    wb(1'b1, sx_pkg::ADDR_CONFIG, 32'h0);
  endtask
  task automatic t_move;
    wb(1'b1, sx_pkg::ADDR_SPEED, 32'h0008_0002);
    s = net;
    cmd(4'h7, 32'd5, F_OK, sx_pkg::ST_NONE);
    wait_idle();
    check("steps", 32'(net - s), 32'd5);
    cmd(4'h7, 32'd5, F_OK, sx_pkg::ST_NONE);
    wait_idle();
    check("steps", 32'(net - s), 32'd5);
    cmd(4'h5, 32'd3, F_OK, sx_pkg::ST_NONE);
    rd("pos", sx_pkg::ADDR_POS, 32'd2);
    cmd(4'h5, 32'd0, F_OK, sx_pkg::ST_NONE);
    rd("pos", sx_pkg::ADDR_POS, 32'd0);
    cmd(4'h7, 32'hffff_fffd, F_NEG, sx_pkg::ST_NONE);
    wait_idle();
    rd("pos", sx_pkg::ADDR_POS, 32'hffff_fffd);
    cmd(4'h7, 32'd0, F_OK, sx_pkg::ST_NONE);
    wait_idle();
    rd("pos", sx_pkg::ADDR_POS, 32'd0);
    check("steps", 32'(net - s), 32'd5);
    cmd(4'h7, 32'h0080_0000, F_OK, sx_pkg::ST_RANGE);
    cmd(4'h7, 32'd0, 4'h0, sx_pkg::ST_PARAM);
    cmd(4'h5, 32'h0080_0000, F_OK, sx_pkg::ST_PARAM);
    cmd(4'h7, 32'd7, F_OK, sx_pkg::ST_NONE);
    wait_idle();
    cmd(4'h4, 32'd0, 4'h0, sx_pkg::ST_NONE);
    rd("pos", sx_pkg::ADDR_POS, 32'd0);
  endtask
  task automatic t_decel;
    wb(1'b1, sx_pkg::ADDR_OUTS, 32'h0);
    s = net;
    cmd(4'h7, 32'd1000, F_OK, sx_pkg::ST_NONE);
    repeat (20) @(posedge clk_i);
    cmd(4'h4, 32'd0, 4'h0, sx_pkg::ST_STATE);
    cmd(4'h3, 32'd20, F_OK, sx_pkg::ST_STATE);
    cmd(4'h8, 32'd0, 4'h0, sx_pkg::ST_NONE);
    wait_idle();
    check("outs", outs, 32'hff);
    check("short", 32'(net - s < 1000), 32'd1);
    rd("pos", sx_pkg::ADDR_POS, 32'(net - s));
    cmd(4'ha, 32'd0, 4'h0, sx_pkg::ST_MEMRST);
    rd("pos", sx_pkg::ADDR_POS, 32'd0);
  endtask
  task automatic t_seq;
    seq_run <= 1'b1;
    cmd(4'h3, 32'd20, F_OK, sx_pkg::ST_STATE);
    check("slip", slip, 32'd255);
    s = aborts;
    cmd(4'h8, 32'd0, 4'h0, sx_pkg::ST_NONE);
    check("abort", 32'(aborts - s), 32'd1);
    seq_run <= 1'b0;
  endtask
  task automatic t_power;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("rel", rel_cnt, 32'd999998);
    rd("pos", sx_pkg::ADDR_POS, 32'd0);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_params();
    t_move();
    t_decel();
    t_seq();
    t_power();
    wrap_up();
  end
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- tb/sx_nv_model.sv ----
// Purpose: Non-volatile store that keeps the relative step count
// Assumes: Same clock as the block, store on a one-cycle pulse
// Notes:   Contents survive the block's reset
`timescale 1ns/1ps
`default_nettype none
module sx_nv_model #(
  parameter logic [19:0] INIT = 20'h01234
) (
  input  wire logic        clk_i,
  input  wire logic        nv_write_i,
  input  wire logic [19:0] rel_count_i,
  output logic      [19:0] nv_rel_count_o
);
  logic [19:0] mem_reg = INIT;
  assign nv_rel_count_o = mem_reg;
  // Stored value outlives reset
  always @(posedge clk_i) begin
    if (nv_write_i === 1'b1) mem_reg <= rel_count_i;
  end
endmodule
`default_nettype wire
